//--- rtl/drive_level_detection_flags.v
// Frequency, current and torque level flags with ramp time and jog selection
//
// Overview of operation
// - Frequency-arrival flag on while running frequency is within band of target.
// - Arrival band width is percent of maximum frequency, default zero.
// - With skip-in-ramp set, ramping frequency inside skip band jumps its boundary.
// - Accelerating: time 2 below switching point, time 1 above; point default 0.
// - Decelerating: time 1 above switching point, time 2 below it.
// - Frequency-range ramp choice replaces terminal ramp-time selection.
// - With jog priority set, terminal jog during run switches to jog running.
// - Second level detector mirrors first; level 50.00Hz, hysteresis 5.0% of level.
// - Level flag sets at or above level, clears below level minus hysteresis.
// - Two arbitrary frequency detectors flag frequency within plus/minus width.
// - Zero-current flag after current at or below level longer than delay.
// - Zero-current level 0..300.0% of rated; delay 0.01s..600.00s.
// - Overcurrent flag after current above limit longer than delay.
// - Current limit 0.0% disables overcurrent detection; otherwise up to 300.0%.
// - Two current-arrival flags while current is within plus/minus width of level.
// - Torque flag after torque reached level longer than torque delay.
`timescale 1ns/1ps
`default_nettype none
`include "drive_level_detection_flags_regs.vh"
module drive_level_detection_flags #(
   parameter [19:0] CTRL_CYCLES     = `CTRL_PERIOD_US * 1000 / `MCLK_PERIOD_NS,
   parameter [19:0] DELAY_UNIT_CTRL = `DELAY_UNIT_US / `CTRL_PERIOD_US
) (
   // Clock and reset
   input  wire        MCLK,
   input  wire        RST_N,
   // Measured values (0.01 Hz, 0.1 % of rated)
   input  wire [15:0] OUT_FREQ,
   input  wire [15:0] TARGET_FREQ,
   input  wire [15:0] MAX_FREQ,
   input  wire [11:0] OUT_CURRENT,
   input  wire [11:0] OUT_TORQUE,
   // Run state
   input  wire        RUN,
   input  wire        ACCEL,
   input  wire        DECEL,
   input  wire        JOG_CMD,
   // Ramp, skip and jog settings
   input  wire [15:0] RAMP_FREQ,
   input  wire        SKIP_IN_RAMP_EN,
   input  wire [15:0] SKIP_FREQ_1,
   input  wire [15:0] SKIP_FREQ_2,
   input  wire [15:0] SKIP_AMPL,
   input  wire [15:0] ACC_SW_POINT,
   input  wire [15:0] DEC_SW_POINT,
   input  wire [1:0]  TERM_RAMP_GROUP,
   input  wire        JOG_PRIORITY_EN,
   // Frequency detection settings
   input  wire [11:0] ARRIVE_WIDTH,
   input  wire [15:0] FDT_LEVEL_1,
   input  wire [11:0] FDT_HYST_1,
   input  wire [15:0] FDT_LEVEL_2,
   input  wire [11:0] FDT_HYST_2,
   input  wire [15:0] ARB_FREQ_1,
   input  wire [11:0] ARB_WIDTH_1,
   input  wire [15:0] ARB_FREQ_2,
   input  wire [11:0] ARB_WIDTH_2,
   // Current and torque settings (delays in 0.01 s)
   input  wire [11:0] ZERO_CUR_LEVEL,
   input  wire [15:0] ZERO_CUR_DELAY,
   input  wire [11:0] OVER_CUR_LIMIT,
   input  wire [15:0] OVER_CUR_DELAY,
   input  wire [11:0] CUR_ARRIVE_1,
   input  wire [11:0] CUR_WIDTH_1,
   input  wire [11:0] CUR_ARRIVE_2,
   input  wire [11:0] CUR_WIDTH_2,
   input  wire [11:0] TORQUE_LEVEL,
   input  wire [15:0] TORQUE_DELAY,
   // Flags
   output wire        FREQ_ARRIVED,
   output wire        FREQ_LEVEL_DETECTOR_ONE,
   output wire        FREQ_LEVEL_DETECTOR_TWO,
   output wire        ARB_FREQ_ARRIVED_1,
   output wire        ARB_FREQ_ARRIVED_2,
   output wire        ZERO_CURRENT,
   output wire        OVER_CURRENT,
   output wire        CUR_ARRIVED_1,
   output wire        CUR_ARRIVED_2,
   output wire        TORQUE_ARRIVED,
   // Ramp and jog results, control cycle strobe
   output wire [15:0] CMD_FREQ,
   output wire [1:0]  RAMP_GROUP,
   output wire        JOG_RUN,
   output wire        CTRL_TICK
);

   // Value times percentage in 0.1 % steps
   function [15:0] pct_of;
      input [15:0] value;
      input [11:0] pct;
      reg   [27:0] prod;
      begin
         prod   = {12'h000, value} * {16'h0000, pct};
         prod   = prod / `PCT_FULL_SCALE;
         pct_of = prod[15:0];
      end
   endfunction

   function [16:0] absdiff;
      input [15:0] a;
      input [15:0] b;
      begin
         absdiff = (a >= b) ? {1'b0, a - b} : {1'b0, b - a};
      end
   endfunction
   function [15:0] clip;
      input [15:0] v;
      input [15:0] lo;
      input [15:0] hi;
      begin
         clip = (v < lo) ? lo : ((v > hi) ? hi : v);
      end
   endfunction
   // Skip across one band in the ramp direction
   function [15:0] skip_band;
      input [15:0] f;
      input [15:0] centre;
      input [15:0] ampl;
      input        up;
      reg   [16:0] lo;
      reg   [16:0] hi;
      begin
         lo = (centre > ampl) ? {1'b0, centre - ampl} : 17'h00000;
         hi = {1'b0, centre} + {1'b0, ampl};
         if (hi > 17'h0FFFF) begin
            hi = 17'h0FFFF;
         end
         if (centre != 16'h0000 && {1'b0, f} > lo && {1'b0, f} < hi) begin
            skip_band = up ? hi[15:0] : lo[15:0];
         end else begin
            skip_band = f;
         end
      end
   endfunction

   // Reset release through two flip-flops
   reg rst_meta_reg;
   reg rst_sync_reg;
   always @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end
   wire rst_n = rst_sync_reg;

   // Control cycle strobe
   reg [19:0] div_reg;
   reg        tick_reg;
   always @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         div_reg  <= 20'h00000;
         tick_reg <= 1'b0;
      end else if (div_reg >= CTRL_CYCLES - 20'h00001) begin
         div_reg  <= 20'h00000;
         tick_reg <= 1'b1;
      end else begin
         div_reg  <= div_reg + 20'h00001;
         tick_reg <= 1'b0;
      end
   end
   assign CTRL_TICK = tick_reg;

   wire [15:0] arrive_band = pct_of(MAX_FREQ, ARRIVE_WIDTH);
   // Paired detectors
   wire [31:0] fdt_level_bus = {FDT_LEVEL_2, FDT_LEVEL_1};
   wire [23:0] fdt_hyst_bus  = {FDT_HYST_2, FDT_HYST_1};
   wire [31:0] arb_freq_bus  = {ARB_FREQ_2, ARB_FREQ_1};
   wire [23:0] arb_width_bus = {ARB_WIDTH_2, ARB_WIDTH_1};
   wire [23:0] cur_lvl_bus   = {CUR_ARRIVE_2, CUR_ARRIVE_1};
   wire [23:0] cur_width_bus = {CUR_WIDTH_2, CUR_WIDTH_1};
   reg  [1:0]  fdt_reg;
   reg  [1:0]  arb_reg;
   reg  [1:0]  cur_reg;
   genvar i;
   generate
      for (i = 0; i < 2; i = i + 1) begin : g_pair
         wire [15:0] lvl     = fdt_level_bus[16*i+15:16*i];
         wire [15:0] hyst    = pct_of(lvl, fdt_hyst_bus[12*i+11:12*i]);
         wire [15:0] release_pt = lvl - hyst;
         wire [15:0] arb_f   = arb_freq_bus[16*i+15:16*i];
         wire [15:0] arb_w   = pct_of(MAX_FREQ, arb_width_bus[12*i+11:12*i]);
         wire [15:0] c_lvl   = {4'h0, cur_lvl_bus[12*i+11:12*i]};
         wire [15:0] c_w     = {4'h0, cur_width_bus[12*i+11:12*i]};
         always @(posedge MCLK or negedge rst_n) begin
            if (!rst_n) begin
               fdt_reg[i] <= 1'b0;
               arb_reg[i] <= 1'b0;
               cur_reg[i] <= 1'b0;
            end else if (tick_reg) begin
               if (OUT_FREQ >= lvl) begin
                  fdt_reg[i] <= 1'b1;
               end else if (OUT_FREQ < release_pt) begin
                  fdt_reg[i] <= 1'b0;
               end
               arb_reg[i] <= absdiff(OUT_FREQ, arb_f) <= {1'b0, arb_w};
               cur_reg[i] <= absdiff({4'h0, OUT_CURRENT}, c_lvl) <= {1'b0, c_w};
            end
         end
      end
   endgenerate

   assign FREQ_LEVEL_DETECTOR_ONE = fdt_reg[0];
   assign FREQ_LEVEL_DETECTOR_TWO = fdt_reg[1];
   assign ARB_FREQ_ARRIVED_1      = arb_reg[0];
   assign ARB_FREQ_ARRIVED_2      = arb_reg[1];
   assign CUR_ARRIVED_1           = cur_reg[0];
   assign CUR_ARRIVED_2           = cur_reg[1];

   // Frequency arrival, ramp selection, skip and jog
   reg         arrive_reg;
   reg  [1:0]  ramp_group_reg;
   reg  [1:0]  ramp_group_next;
   reg  [15:0] cmd_freq_reg;
   reg  [15:0] cmd_freq_next;
   reg         jog_reg;

   always @* begin
      ramp_group_next = TERM_RAMP_GROUP;
      if (ACCEL && ACC_SW_POINT != 16'h0000) begin
         ramp_group_next = (OUT_FREQ < ACC_SW_POINT) ? `RAMP_GROUP_TWO
                                                     : `RAMP_GROUP_ONE;
      end else if (DECEL && DEC_SW_POINT != 16'h0000) begin
         ramp_group_next = (OUT_FREQ < DEC_SW_POINT) ? `RAMP_GROUP_TWO
                                                     : `RAMP_GROUP_ONE;
      end
      cmd_freq_next = RAMP_FREQ;
      if (SKIP_IN_RAMP_EN && (ACCEL || DECEL)) begin
         cmd_freq_next = skip_band(skip_band(RAMP_FREQ, SKIP_FREQ_1, SKIP_AMPL, ACCEL),
                                   SKIP_FREQ_2, SKIP_AMPL, ACCEL);
      end
   end

   always @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         arrive_reg     <= 1'b0;
         ramp_group_reg <= `RAMP_GROUP_ONE;
         cmd_freq_reg   <= 16'h0000;
         jog_reg        <= 1'b0;
      end else if (tick_reg) begin
         arrive_reg     <= absdiff(OUT_FREQ, TARGET_FREQ) <= {1'b0, arrive_band};
         ramp_group_reg <= ramp_group_next;
         cmd_freq_reg   <= cmd_freq_next;
         jog_reg        <= JOG_CMD && (!RUN || JOG_PRIORITY_EN);
      end
   end

   assign FREQ_ARRIVED = arrive_reg;
   assign RAMP_GROUP   = ramp_group_reg;
   assign CMD_FREQ     = cmd_freq_reg;
   assign JOG_RUN      = jog_reg;

   // Delay-qualified detectors
   wire [15:0] zc_delay = clip(ZERO_CUR_DELAY, `ZERO_CUR_DELAY_MIN, `DELAY_MAX_UNITS);
   wire [15:0] oc_delay = clip(OVER_CUR_DELAY, 16'h0000, `DELAY_MAX_UNITS);
   wire [15:0] tq_delay = clip(TORQUE_DELAY, 16'h0000, `DELAY_MAX_UNITS);
   wire [19:0] zc_limit = {4'h0, zc_delay} * DELAY_UNIT_CTRL;
   wire [19:0] oc_limit = {4'h0, oc_delay} * DELAY_UNIT_CTRL;
   wire [19:0] tq_limit = {4'h0, tq_delay} * DELAY_UNIT_CTRL;
   wire [11:0] zc_level = (ZERO_CUR_LEVEL > `CURRENT_MAX) ? `CURRENT_MAX : ZERO_CUR_LEVEL;
   wire [11:0] oc_level = (OVER_CUR_LIMIT > `CURRENT_MAX) ? `CURRENT_MAX : OVER_CUR_LIMIT;
   wire zc_cond = OUT_CURRENT <= zc_level;
   wire oc_cond = (oc_level != 12'h000) && (OUT_CURRENT > oc_level);
   wire tq_cond = OUT_TORQUE >= TORQUE_LEVEL;
   delay_qualifier u_zero_current (
      .clk   (MCLK),
      .rst_n (rst_n),
      .tick  (tick_reg),
      .cond  (zc_cond),
      .limit (zc_limit),
      .flag  (ZERO_CURRENT)
   );
   delay_qualifier u_over_current (
      .clk   (MCLK),
      .rst_n (rst_n),
      .tick  (tick_reg),
      .cond  (oc_cond),
      .limit (oc_limit),
      .flag  (OVER_CURRENT)
   );
   delay_qualifier u_torque (
      .clk   (MCLK),
      .rst_n (rst_n),
      .tick  (tick_reg),
      .cond  (tq_cond),
      .limit (tq_limit),
      .flag  (TORQUE_ARRIVED)
   );

endmodule
`default_nettype wire

//--- rtl/drive_level_detection_flags_regs.vh
// Constants for the drive level detection flags block
`ifndef DRIVE_LEVEL_DETECTION_FLAGS_REGS_VH
`define DRIVE_LEVEL_DETECTION_FLAGS_REGS_VH

// Timing
`define MCLK_PERIOD_NS        10
`define CTRL_PERIOD_US        1000
`define DELAY_UNIT_US         10000
`define DELAY_MAX_UNITS       16'hEA60
`define ZERO_CUR_DELAY_MIN    16'h0001

// Scaling: percentages in 0.1 % steps, 1000 equals 100.0 %
`define PCT_FULL_SCALE        28'h00003E8
`define CURRENT_MAX           12'hBB8

// Ramp time groups
`define RAMP_GROUP_ONE        2'h0
`define RAMP_GROUP_TWO        2'h1

// Setting defaults
`define ARRIVE_WIDTH_DEFAULT  12'h000
`define SKIP_IN_RAMP_DEFAULT  1'h0
`define SW_POINT_DEFAULT      16'h0000
`define JOG_PRIORITY_DEFAULT  1'h0
`define FDT_LEVEL_DEFAULT     16'h1388
`define FDT_HYST_DEFAULT      12'h032
`define ARB_FREQ_DEFAULT      16'h1388
`define ARB_WIDTH_DEFAULT     12'h000
`define ZERO_CUR_LVL_DEFAULT  12'h032
`define ZERO_CUR_DLY_DEFAULT  16'h000A
`define OVER_CUR_LIM_DEFAULT  12'h7D0
`define OVER_CUR_DLY_DEFAULT  16'h0000
`define CUR_ARRIVE_DEFAULT    12'h1F4
`define CUR_WIDTH_DEFAULT     12'h003
`define TORQUE_LVL_DEFAULT    12'h3E8
`define TORQUE_DLY_DEFAULT    16'h0000

`endif

//--- rtl/delay_qualifier.v
// Condition timer that raises a flag once a condition has held past a limit
`timescale 1ns/1ps
`default_nettype none
module delay_qualifier (
   // Clock and reset
   input  wire        clk,
   input  wire        rst_n,
   // Control cycle strobe
   input  wire        tick,
   // Condition and limit in control cycles
   input  wire        cond,
   input  wire [19:0] limit,
   // Qualified flag
   output reg         flag
);

   reg [19:0] count_reg;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= 20'h00000;
         flag      <= 1'b0;
      end else if (tick) begin
         if (!cond) begin
            count_reg <= 20'h00000;
            flag      <= 1'b0;
         end else if (count_reg >= limit) begin
            flag <= 1'b1;
         end else begin
            count_reg <= count_reg + 20'h00001;
         end
      end
   end

endmodule
`default_nettype wire

//--- verif/drive_level_detection_flags_properties.sv
// Concurrent checks on the level detection flag outputs
`timescale 1ns/1ps
`default_nettype none
`include "drive_level_detection_flags_regs.vh"
module drive_level_detection_flags_properties (
   input wire logic        MCLK, RST_N, CTRL_TICK, RUN, ACCEL, DECEL, JOG_CMD, JOG_PRIORITY_EN,
   input wire logic [15:0] OUT_FREQ, TARGET_FREQ, MAX_FREQ, FDT_LEVEL_1, ACC_SW_POINT,
   input wire logic [11:0] ARRIVE_WIDTH, FDT_HYST_1, OUT_CURRENT, OVER_CUR_LIMIT,
   input wire logic [15:0] OVER_CUR_DELAY,
   input wire logic        FREQ_ARRIVED, FREQ_LEVEL_DETECTOR_ONE, OVER_CURRENT, JOG_RUN,
   input wire logic        ZERO_CURRENT, TORQUE_ARRIVED,
   input wire logic [1:0]  RAMP_GROUP
);
   wire [15:0] fdiff = (OUT_FREQ > TARGET_FREQ) ? OUT_FREQ - TARGET_FREQ : TARGET_FREQ - OUT_FREQ;
   wire [27:0] band  = MAX_FREQ * ARRIVE_WIDTH / `PCT_FULL_SCALE;
   wire [27:0] hlow  = FDT_LEVEL_1 - FDT_LEVEL_1 * FDT_HYST_1 / `PCT_FULL_SCALE;
   wire [4:0]  flags = {FREQ_ARRIVED, FREQ_LEVEL_DETECTOR_ONE, OVER_CURRENT, ZERO_CURRENT, JOG_RUN};
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_N);
   // Frequency between the release point and the level: the flag keeps its state
   sequence in_hyst_s;
      CTRL_TICK && OUT_FREQ < FDT_LEVEL_1 && {12'h000, OUT_FREQ} >= hlow;
   endsequence
   arrive_band_a: assert property (CTRL_TICK |=> FREQ_ARRIVED == $past({12'h000, fdiff} <= band))
      else $error("arrival flag disagrees with band");
   level_set_a: assert property (CTRL_TICK && OUT_FREQ >= FDT_LEVEL_1 |=> FREQ_LEVEL_DETECTOR_ONE)
      else $error("level flag not set at level");
   level_hold_a: assert property (in_hyst_s |=> $stable(FREQ_LEVEL_DETECTOR_ONE))
      else $error("level flag moved inside hysteresis");
   overcur_now_a: assert property (CTRL_TICK && OVER_CUR_LIMIT != 12'h000 && OVER_CUR_DELAY == 16'h0000
      |=> OVER_CURRENT == $past(OUT_CURRENT > OVER_CUR_LIMIT)) else $error("overcurrent flag wrong");
   overcur_off_a: assert property (CTRL_TICK && OVER_CUR_LIMIT == 12'h000 |=> !OVER_CURRENT)
      else $error("overcurrent flag with limit zero");
   ramp_accel_a: assert property (CTRL_TICK && ACCEL && !DECEL && ACC_SW_POINT != 16'h0000
      |=> RAMP_GROUP == ($past(OUT_FREQ < ACC_SW_POINT) ? `RAMP_GROUP_TWO : `RAMP_GROUP_ONE))
      else $error("acceleration group wrong");
   jog_state_a: assert property (CTRL_TICK |=> JOG_RUN == $past(JOG_CMD && (!RUN || JOG_PRIORITY_EN)))
      else $error("jog state wrong");
   flags_hold_a: assert property (!CTRL_TICK |=> $stable(flags) && $stable(TORQUE_ARRIVED))
      else $error("flag changed between ticks");
endmodule
bind drive_level_detection_flags drive_level_detection_flags_properties u_props (
   .MCLK(MCLK), .RST_N(RST_N), .CTRL_TICK(CTRL_TICK), .RUN(RUN), .ACCEL(ACCEL), .DECEL(DECEL),
   .JOG_CMD(JOG_CMD), .JOG_PRIORITY_EN(JOG_PRIORITY_EN), .OUT_FREQ(OUT_FREQ),
   .TARGET_FREQ(TARGET_FREQ), .MAX_FREQ(MAX_FREQ), .FDT_LEVEL_1(FDT_LEVEL_1),
   .ACC_SW_POINT(ACC_SW_POINT), .ARRIVE_WIDTH(ARRIVE_WIDTH), .FDT_HYST_1(FDT_HYST_1),
   .OUT_CURRENT(OUT_CURRENT), .OVER_CUR_LIMIT(OVER_CUR_LIMIT), .OVER_CUR_DELAY(OVER_CUR_DELAY),
   .FREQ_ARRIVED(FREQ_ARRIVED), .FREQ_LEVEL_DETECTOR_ONE(FREQ_LEVEL_DETECTOR_ONE),
   .OVER_CURRENT(OVER_CURRENT), .JOG_RUN(JOG_RUN), .ZERO_CURRENT(ZERO_CURRENT),
   .TORQUE_ARRIVED(TORQUE_ARRIVED), .RAMP_GROUP(RAMP_GROUP));
`default_nettype wire

//--- verif/drive_model.sv
// Behavioural control loop presenting measured frequency, current and torque
`timescale 1ns/1ps
`default_nettype none
module drive_model (
   input  wire logic        clk,
   input  wire logic [15:0] freq_set,
   input  wire logic [11:0] cur_set,
   input  wire logic [11:0] torque_set,
   output var  logic [15:0] freq,
   output var  logic [11:0] current,
   output var  logic [11:0] torque
);
   // Measurements move just after an edge, never on the sampling edge itself
   always @(posedge clk) begin
      freq    <= #1 freq_set;
      current <= #1 cur_set;
      torque  <= #1 torque_set;
   end
endmodule
`default_nettype wire

//--- verif/tb.sv
// Self-checking bench for the drive level detection flags block
`timescale 1ns/1ps
`default_nettype none
`include "drive_level_detection_flags_regs.vh"
module tb;
   typedef struct {logic [15:0] f, t; logic [11:0] c; logic run, jog, pri, fa, oc, jr; logic [1:0] rg;} row_t;
   logic        MCLK = 1'b0, RST_N = 1'b0, RUN, ACCEL, DECEL, JOG_CMD, SKIP_IN_RAMP_EN, JOG_PRIORITY_EN;
   logic [15:0] f_set, TARGET_FREQ, MAX_FREQ, RAMP_FREQ, SKIP_FREQ_1, SKIP_FREQ_2, SKIP_AMPL;
   logic [15:0] ACC_SW_POINT, DEC_SW_POINT, FDT_LEVEL_1, FDT_LEVEL_2, ARB_FREQ_1, ARB_FREQ_2;
   logic [15:0] ZERO_CUR_DELAY, OVER_CUR_DELAY, TORQUE_DELAY, OUT_FREQ, CMD_FREQ;
   logic [11:0] c_set, q_set, ARRIVE_WIDTH, FDT_HYST_1, FDT_HYST_2, ARB_WIDTH_1, ARB_WIDTH_2;
   logic [11:0] ZERO_CUR_LEVEL, OVER_CUR_LIMIT, CUR_ARRIVE_1, CUR_WIDTH_1, CUR_ARRIVE_2;
   logic [11:0] CUR_WIDTH_2, TORQUE_LEVEL, OUT_CURRENT, OUT_TORQUE;
   logic [1:0]  TERM_RAMP_GROUP, RAMP_GROUP;
   logic        FREQ_ARRIVED, FREQ_LEVEL_DETECTOR_ONE, FREQ_LEVEL_DETECTOR_TWO, ARB_FREQ_ARRIVED_1;
   logic        ARB_FREQ_ARRIVED_2, ZERO_CURRENT, OVER_CURRENT, CUR_ARRIVED_1, CUR_ARRIVED_2;
   logic        TORQUE_ARRIVED, JOG_RUN, CTRL_TICK;
   int          n_mismatch = 0, checks = 0, cyc = 0;
   row_t        rows [4] = '{
      '{16'h0BB8, 16'h0C1C, 12'h7D0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 2'h0},
      '{16'h0BB8, 16'h0C1D, 12'h7D1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 2'h0},
      '{16'h07CF, 16'h076B, 12'h7CF, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 2'h1},
      '{16'h07D0, 16'h07D0, 12'h000, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 2'h0}};
   logic [15:0] lv [5] = '{16'h1388, 16'h128E, 16'h128D, 16'h1387, 16'h1388};
   logic [4:0]  le = 5'b10011;
   drive_model u_drive_model (.clk(MCLK), .freq_set(f_set), .cur_set(c_set), .torque_set(q_set),
      .freq(OUT_FREQ), .current(OUT_CURRENT), .torque(OUT_TORQUE));
   drive_level_detection_flags #(.CTRL_CYCLES(20'h00004), .DELAY_UNIT_CTRL(20'h00001))
   u_drive_level_detection_flags (.MCLK(MCLK), .RST_N(RST_N), .OUT_FREQ(OUT_FREQ),
      .TARGET_FREQ(TARGET_FREQ), .MAX_FREQ(MAX_FREQ), .OUT_CURRENT(OUT_CURRENT),
      .OUT_TORQUE(OUT_TORQUE), .RUN(RUN), .ACCEL(ACCEL), .DECEL(DECEL), .JOG_CMD(JOG_CMD),
      .RAMP_FREQ(RAMP_FREQ), .SKIP_IN_RAMP_EN(SKIP_IN_RAMP_EN), .SKIP_FREQ_1(SKIP_FREQ_1),
      .SKIP_FREQ_2(SKIP_FREQ_2), .SKIP_AMPL(SKIP_AMPL), .ACC_SW_POINT(ACC_SW_POINT),
      .DEC_SW_POINT(DEC_SW_POINT), .TERM_RAMP_GROUP(TERM_RAMP_GROUP),
      .JOG_PRIORITY_EN(JOG_PRIORITY_EN), .ARRIVE_WIDTH(ARRIVE_WIDTH), .FDT_LEVEL_1(FDT_LEVEL_1),
      .FDT_HYST_1(FDT_HYST_1), .FDT_LEVEL_2(FDT_LEVEL_2), .FDT_HYST_2(FDT_HYST_2),
      .ARB_FREQ_1(ARB_FREQ_1), .ARB_WIDTH_1(ARB_WIDTH_1), .ARB_FREQ_2(ARB_FREQ_2),
      .ARB_WIDTH_2(ARB_WIDTH_2), .ZERO_CUR_LEVEL(ZERO_CUR_LEVEL), .ZERO_CUR_DELAY(ZERO_CUR_DELAY),
      .OVER_CUR_LIMIT(OVER_CUR_LIMIT), .OVER_CUR_DELAY(OVER_CUR_DELAY),
      .CUR_ARRIVE_1(CUR_ARRIVE_1), .CUR_WIDTH_1(CUR_WIDTH_1), .CUR_ARRIVE_2(CUR_ARRIVE_2),
      .CUR_WIDTH_2(CUR_WIDTH_2), .TORQUE_LEVEL(TORQUE_LEVEL), .TORQUE_DELAY(TORQUE_DELAY),
      .FREQ_ARRIVED(FREQ_ARRIVED), .FREQ_LEVEL_DETECTOR_ONE(FREQ_LEVEL_DETECTOR_ONE),
      .FREQ_LEVEL_DETECTOR_TWO(FREQ_LEVEL_DETECTOR_TWO), .ARB_FREQ_ARRIVED_1(ARB_FREQ_ARRIVED_1),
      .ARB_FREQ_ARRIVED_2(ARB_FREQ_ARRIVED_2), .ZERO_CURRENT(ZERO_CURRENT),
      .OVER_CURRENT(OVER_CURRENT), .CUR_ARRIVED_1(CUR_ARRIVED_1), .CUR_ARRIVED_2(CUR_ARRIVED_2),
      .TORQUE_ARRIVED(TORQUE_ARRIVED), .CMD_FREQ(CMD_FREQ), .RAMP_GROUP(RAMP_GROUP),
      .JOG_RUN(JOG_RUN), .CTRL_TICK(CTRL_TICK));
   always #5 MCLK = ~MCLK;
   task automatic conclude;
      if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge MCLK) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         n_mismatch = n_mismatch + 1;
         conclude;
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks = checks + 1;
      if (seen !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Waits for n control ticks and lets the updated outputs settle
   task automatic ticks(input int n);
      repeat (n) begin
         do begin
            @(posedge MCLK);
            #1;
         end while (CTRL_TICK !== 1'b1);
         @(posedge MCLK);
         #1;
      end
   endtask
   initial begin
      {RUN, ACCEL, DECEL, JOG_CMD, SKIP_IN_RAMP_EN, JOG_PRIORITY_EN} = 6'h10;
      {f_set, TARGET_FREQ, MAX_FREQ, RAMP_FREQ} = {16'h0000, 16'h0000, 16'h1388, 16'h0802};
      {SKIP_FREQ_1, SKIP_FREQ_2, SKIP_AMPL} = {16'h07D0, 16'h0000, 16'h0064};
      {ACC_SW_POINT, DEC_SW_POINT, TERM_RAMP_GROUP} = {16'h07D0, 16'h07D0, 2'h3};
      {FDT_LEVEL_1, FDT_LEVEL_2, FDT_HYST_1, FDT_HYST_2} = {16'h1388, 16'h1388, 12'h032, 12'h032};
      {ARB_FREQ_1, ARB_FREQ_2, ARB_WIDTH_1, ARB_WIDTH_2} = {16'h0BB8, 16'h0BB8, 12'h00A, 12'h009};
      {ZERO_CUR_LEVEL, ZERO_CUR_DELAY, OVER_CUR_LIMIT, OVER_CUR_DELAY} = {12'h032, 16'h3, 12'h7D0, 16'h0};
      {CUR_ARRIVE_1, CUR_ARRIVE_2, CUR_WIDTH_1, CUR_WIDTH_2} = {12'h1F4, 12'h1F4, 12'h003, 12'h002};
      {TORQUE_LEVEL, TORQUE_DELAY, c_set, q_set, ARRIVE_WIDTH} = {12'h3E8, 16'h0, 12'h0, 12'h0, 12'h014};
      repeat (5) @(posedge MCLK);
      chk(RAMP_GROUP, 16'h0000);
      chk(CMD_FREQ, 16'h0000);
      #1 RST_N = 1'b1;
      foreach (rows[i]) begin
         {f_set, TARGET_FREQ, c_set} = {rows[i].f, rows[i].t, rows[i].c};
         {RUN, JOG_CMD, JOG_PRIORITY_EN} = {rows[i].run, rows[i].jog, rows[i].pri};
         ticks(1);
         chk(FREQ_ARRIVED, rows[i].fa);
         chk(OVER_CURRENT, rows[i].oc);
         chk(JOG_RUN, rows[i].jr);
         chk(RAMP_GROUP, rows[i].rg);
         chk(CTRL_TICK, 16'h0000);
      end
      chk(CMD_FREQ, 16'h0802);
      SKIP_IN_RAMP_EN = 1'b1;
      ticks(1);
      chk(CMD_FREQ, 16'h0834);
      {ACCEL, DECEL, f_set} = {1'b0, 1'b1, 16'h05DC};
      ticks(1);
      chk(CMD_FREQ, 16'h076C);
      chk(RAMP_GROUP, `RAMP_GROUP_TWO);
      f_set = 16'h09C4;
      ticks(1);
      chk(RAMP_GROUP, `RAMP_GROUP_ONE);
      {DEC_SW_POINT, SKIP_IN_RAMP_EN} = {16'h0000, 1'b0};
      ticks(1);
      chk(RAMP_GROUP, 16'h0003);
      foreach (lv[i]) begin
         f_set = lv[i];
         ticks(1);
         chk(FREQ_LEVEL_DETECTOR_ONE, le[i]);
         chk(FREQ_LEVEL_DETECTOR_TWO, le[i]);
      end
      {f_set, c_set, q_set} = {16'h0BEA, 12'h1F7, 12'h3E8};
      ticks(1);
      chk({ARB_FREQ_ARRIVED_1, ARB_FREQ_ARRIVED_2}, 16'h0002);
      chk({CUR_ARRIVED_1, CUR_ARRIVED_2}, 16'h0002);
      chk(TORQUE_ARRIVED, 16'h0001);
      {c_set, q_set} = {12'h032, 12'h3E7};
      ticks(3);
      chk(ZERO_CURRENT, 16'h0000);
      chk(TORQUE_ARRIVED, 16'h0000);
      ticks(1);
      chk(ZERO_CURRENT, 16'h0001);
      c_set = 12'h033;
      ticks(1);
      chk(ZERO_CURRENT, 16'h0000);
      c_set = 12'h032;
      ticks(3);
      chk(ZERO_CURRENT, 16'h0000);
      {OVER_CUR_DELAY, c_set} = {16'h0002, 12'h7D1};
      ticks(2);
      chk(OVER_CURRENT, 16'h0000);
      ticks(1);
      chk(OVER_CURRENT, 16'h0001);
      {OVER_CUR_LIMIT, c_set} = {12'h000, 12'hBB8};
      ticks(4);
      chk(OVER_CURRENT, 16'h0000);
      conclude;
   end
endmodule
`default_nettype wire
